// ### hw/tlih_top.sv
// two-level interrupt handler with its register slave on axi4-lite
module tlih_top
   import tlih_pkg::*;
#(
   parameter int N = tlih_pkg::TLIH_NUM_SRC,
   parameter logic [15:0] VEC_BASE = tlih_pkg::TLIH_VEC_BASE,
   parameter logic [15:0] VEC_STEP = tlih_pkg::TLIH_VEC_STEP,
   parameter logic [31:0] AUTO_CLR = 32'h0000_000f
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic [tlih_pkg::TLIH_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [tlih_pkg::TLIH_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // peripheral condition pulses
   input wire logic [N-1:0] src_event,
   // core pipeline
   input wire tlih_pkg::tlih_core_ev_s core_ev,
   output tlih_pkg::tlih_call_s call,
   // event interrupt
   output logic irq
);
   import tlih_pkg::*;

   localparam int IW = (N > 1) ? $clog2(N) : 1;

   // refused at elaboration: the pending and state words hold at most 32 sources
   if (N < 1 || N > TLIH_MAX_SRC)
   begin : g_bad_src_count
      $error("source count must be 1 to 32");
   end

   logic [TLIH_ADDR_W-1:0] aw_addr_reg;
   logic aw_have_reg;
   logic [31:0] w_data_reg;
   logic [31:0] w_mask_reg;
   logic w_have_reg;
   logic wr_fire;
   logic [31:0] wbits;
   logic gie_reg;
   logic [N-1:0] en_reg;
   logic [N-1:0] prio_reg;
   logic [N-1:0] pend_reg;
   logic [N-1:0] pend_next;
   logic [N-1:0] sw_set;
   logic [N-1:0] sw_clr;
   logic [N-1:0] hw_clr;
   logic [N-1:0] elig;
   logic win_valid;
   logic win_hi;
   logic [IW-1:0] win_idx;
   logic allowed;
   logic req_reg;
   logic req_next;
   logic req_hi_reg;
   logic [IW-1:0] req_idx_reg;
   logic [TLIH_VEC_W-1:0] vec_reg;
   logic taken;
   logic active_lo_reg;
   logic active_hi_reg;
   logic hold_reg;
   logic [TLIH_EVT_W-1:0] evt_reg;
   logic [TLIH_EVT_W-1:0] evt_mask_reg;
   logic [TLIH_EVT_W-1:0] evt_set;
   logic [31:0] rd_mux;
   logic rd_ok;
   logic wr_ok;

   // write channel: address and data held apart, taken in either order
   assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
   assign wbits = w_data_reg & w_mask_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= '0;
         s_axi_awready <= 1'b1;
         w_have_reg <= 1'b0;
         w_data_reg <= TLIH_ZERO_RST;
         w_mask_reg <= TLIH_ZERO_RST;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= TLIH_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            for (int b = 0; b < 4; b++)
            begin
               w_mask_reg[b*8 +: 8] <= {8{s_axi_wstrb[b]}};
            end
            s_axi_wready <= 1'b0;
         end
         if (wr_fire)
         begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? TLIH_RESP_OKAY : TLIH_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_comb
   begin
      case (aw_addr_reg)
         TLIH_OFS_CTRL, TLIH_OFS_ENABLE, TLIH_OFS_PRIO, TLIH_OFS_PEND,
         TLIH_OFS_PEND_CLR, TLIH_OFS_STATE, TLIH_OFS_EVT, TLIH_OFS_EVT_MASK:
            wr_ok = 1'b1;
         default:
            wr_ok = 1'b0;
      endcase
   end

   // configuration registers, byte enables honoured
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         gie_reg <= TLIH_GIE_RST;
         en_reg <= '0;
         prio_reg <= '0;
         evt_mask_reg <= '0;
      end
      else if (wr_fire)
      begin
         case (aw_addr_reg)
            TLIH_OFS_CTRL:
               if (w_mask_reg[TLIH_CTRL_GIE_BIT])
               begin
                  gie_reg <= w_data_reg[TLIH_CTRL_GIE_BIT];
               end
            TLIH_OFS_ENABLE:
               en_reg <= (en_reg & ~w_mask_reg[N-1:0]) | wbits[N-1:0];
            TLIH_OFS_PRIO:
               prio_reg <= (prio_reg & ~w_mask_reg[N-1:0]) | wbits[N-1:0];
            TLIH_OFS_EVT_MASK:
               evt_mask_reg <= (evt_mask_reg & ~w_mask_reg[TLIH_EVT_W-1:0])
                  | wbits[TLIH_EVT_W-1:0];
            default:
               begin
               end
         endcase
      end
   end

   // pending flags; a set in the same cycle as a clear wins
   assign sw_set = (wr_fire && aw_addr_reg == TLIH_OFS_PEND) ? wbits[N-1:0] : '0;
   assign sw_clr = (wr_fire && aw_addr_reg == TLIH_OFS_PEND_CLR) ? wbits[N-1:0] : '0;
   assign hw_clr = taken ? (AUTO_CLR[N-1:0] & (N'(1) << req_idx_reg)) : '0;
   assign pend_next = (pend_reg & ~(sw_clr | hw_clr)) | src_event | sw_set;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pend_reg <= '0;
      end
      else
      begin
         pend_reg <= pend_next;
      end
   end

   // global enable gates all; disabled sources simply wait pending
   assign elig = pend_reg & en_reg & {N{gie_reg}};

   tlih_arbiter #(
      .N(N),
      .IW(IW)
   ) u_arb (
      .elig(elig),
      .prio(prio_reg),
      .valid(win_valid),
      .hi(win_hi),
      .idx(win_idx)
   );

   // high may enter over low only; nothing enters over high
   assign allowed = !active_hi_reg && (win_hi || !active_lo_reg);
   assign taken = core_ev.call_ack && req_reg;
   // return and the instruction after it are not interruptible
   assign req_next = win_valid && allowed && !hold_reg && !core_ev.return_from_interrupt && !taken;

   // request re-decided every clock from the sampled flags
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         req_reg <= 1'b0;
         req_hi_reg <= 1'b0;
         req_idx_reg <= '0;
         vec_reg <= '0;
      end
      else
      begin
         req_reg <= req_next;
         req_hi_reg <= win_hi;
         req_idx_reg <= win_idx;
         vec_reg <= VEC_BASE + TLIH_VEC_W'(VEC_STEP * win_idx);
      end
   end

   // in-service levels; a return pops the high level before the low one
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         active_lo_reg <= 1'b0;
         active_hi_reg <= 1'b0;
         hold_reg <= 1'b0;
      end
      else
      begin
         if (taken)
         begin
            if (req_hi_reg)
            begin
               active_hi_reg <= 1'b1;
            end
            else
            begin
               active_lo_reg <= 1'b1;
            end
         end
         else if (core_ev.return_from_interrupt)
         begin
            if (active_hi_reg)
            begin
               active_hi_reg <= 1'b0;
            end
            else
            begin
               active_lo_reg <= 1'b0;
            end
         end
         if (core_ev.return_from_interrupt)
         begin
            hold_reg <= 1'b1;
         end
         else if (core_ev.instr_done)
         begin
            hold_reg <= 1'b0;
         end
      end
   end

   // sticky event bits, write one to clear, set beats clear
   always_comb
   begin
      evt_set = '0;
      evt_set[TLIH_EVT_TAKEN_BIT] = taken;
      evt_set[TLIH_EVT_PREEMPT_BIT] = taken && req_hi_reg && active_lo_reg;
      evt_set[TLIH_EVT_RETURN_FROM_INTERRUPT_BIT] = core_ev.return_from_interrupt;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         evt_reg <= '0;
         irq <= 1'b0;
      end
      else
      begin
         if (wr_fire && aw_addr_reg == TLIH_OFS_EVT)
         begin
            evt_reg <= (evt_reg & ~wbits[TLIH_EVT_W-1:0]) | evt_set;
         end
         else
         begin
            evt_reg <= evt_reg | evt_set;
         end
         irq <= |(evt_reg & evt_mask_reg);
      end
   end

   // read path, one cycle after the address is taken
   always_comb
   begin
      rd_mux = TLIH_ZERO_RST;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         TLIH_OFS_CTRL:
            rd_mux[TLIH_CTRL_GIE_BIT] = gie_reg;
         TLIH_OFS_ENABLE:
            rd_mux[N-1:0] = en_reg;
         TLIH_OFS_PRIO:
            rd_mux[N-1:0] = prio_reg;
         TLIH_OFS_PEND:
            rd_mux[N-1:0] = pend_reg;
         TLIH_OFS_PEND_CLR:
            rd_mux = TLIH_ZERO_RST;
         TLIH_OFS_STATE:
         begin
            rd_mux[TLIH_ST_LO_BIT] = active_lo_reg;
            rd_mux[TLIH_ST_HI_BIT] = active_hi_reg;
            rd_mux[TLIH_ST_HOLD_BIT] = hold_reg;
            rd_mux[TLIH_ST_REQ_BIT] = req_reg;
            rd_mux[TLIH_ST_IDX_LSB +: IW] = req_idx_reg;
         end
         TLIH_OFS_EVT:
            rd_mux[TLIH_EVT_W-1:0] = evt_reg;
         TLIH_OFS_EVT_MASK:
            rd_mux[TLIH_EVT_W-1:0] = evt_mask_reg;
         default:
            rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= TLIH_ZERO_RST;
         s_axi_rresp <= TLIH_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_ok ? TLIH_RESP_OKAY : TLIH_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   assign call.req = req_reg;
   assign call.vec = vec_reg;

   // checks
   sequence s_return_from_interrupt;
      core_ev.return_from_interrupt;
   endsequence

   sequence s_quiet_after;
      !req_reg;
   endsequence

   chk_req_gated: assert property (@(posedge aclk) disable iff (!aresetn)
      req_reg |-> $past(gie_reg) && ($past(elig) != '0))
      else $error("request raised without enables");

   chk_pend_set: assert property (@(posedge aclk) disable iff (!aresetn)
      (src_event != '0) |=> ((pend_reg & $past(src_event)) == $past(src_event)))
      else $error("event did not set pending flag");

   chk_hi_no_preempt: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(active_hi_reg) |-> !req_reg)
      else $error("request while high routine runs");

   chk_lo_needs_hi: assert property (@(posedge aclk) disable iff (!aresetn)
      req_reg && $past(active_lo_reg) |-> req_hi_reg)
      else $error("low request over low routine");

   chk_return_from_interrupt_gap: assert property (@(posedge aclk) disable iff (!aresetn)
      s_return_from_interrupt |=> s_quiet_after ##1 (!req_reg || $past(core_ev.instr_done, 2)
         || $past(core_ev.instr_done)))
      else $error("call too soon after return");

   chk_vec_value: assert property (@(posedge aclk) disable iff (!aresetn)
      req_reg |-> call.vec == VEC_BASE + TLIH_VEC_W'(VEC_STEP * req_idx_reg))
      else $error("wrong vector");

   chk_ack_level: assert property (@(posedge aclk) disable iff (!aresetn)
      taken |=> ($past(req_hi_reg) ? active_hi_reg : active_lo_reg))
      else $error("call not recorded as in service");

   chk_prio_reset: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(!aresetn) |-> prio_reg == '0)
      else $error("priority not low after reset");

   chk_arb_level: assert property (@(posedge aclk) disable iff (!aresetn)
      req_reg && !req_hi_reg |-> ($past(elig & prio_reg) == '0))
      else $error("low chosen over high");

   chk_resume_low: assert property (@(posedge aclk) disable iff (!aresetn)
      core_ev.return_from_interrupt && active_hi_reg && active_lo_reg && !taken
         |=> active_lo_reg && !active_hi_reg)
      else $error("low routine lost on return");
endmodule

// ### hw/tlih_pkg.sv
// shared constants and carrier types of the two-level interrupt handler
package tlih_pkg;
   localparam int TLIH_MAX_SRC = 32;
   localparam int TLIH_NUM_SRC = 19;
   localparam int TLIH_VEC_W = 16;
   localparam logic [15:0] TLIH_VEC_BASE = 16'h0003;
   localparam logic [15:0] TLIH_VEC_STEP = 16'h0008;
   localparam int TLIH_ADDR_W = 8;
   // register byte offsets
   localparam logic [7:0] TLIH_OFS_CTRL = 8'h00;
   localparam logic [7:0] TLIH_OFS_ENABLE = 8'h04;
   localparam logic [7:0] TLIH_OFS_PRIO = 8'h08;
   localparam logic [7:0] TLIH_OFS_PEND = 8'h0c;
   localparam logic [7:0] TLIH_OFS_PEND_CLR = 8'h10;
   localparam logic [7:0] TLIH_OFS_STATE = 8'h14;
   localparam logic [7:0] TLIH_OFS_EVT = 8'h18;
   localparam logic [7:0] TLIH_OFS_EVT_MASK = 8'h1c;
   // field positions
   localparam int TLIH_CTRL_GIE_BIT = 7;
   localparam int TLIH_ST_LO_BIT = 0;
   localparam int TLIH_ST_HI_BIT = 1;
   localparam int TLIH_ST_HOLD_BIT = 2;
   localparam int TLIH_ST_REQ_BIT = 3;
   localparam int TLIH_ST_IDX_LSB = 8;
   localparam int TLIH_EVT_W = 3;
   localparam int TLIH_EVT_TAKEN_BIT = 0;
   localparam int TLIH_EVT_PREEMPT_BIT = 1;
   localparam int TLIH_EVT_RETURN_FROM_INTERRUPT_BIT = 2;
   // reset values
   localparam logic TLIH_GIE_RST = 1'b0;
   localparam logic [31:0] TLIH_ZERO_RST = 32'h0000_0000;
   // bus answers
   localparam logic [1:0] TLIH_RESP_OKAY = 2'b00;
   localparam logic [1:0] TLIH_RESP_SLVERR = 2'b10;

   // strobes from the core pipeline
   typedef struct packed {
      logic instr_done;
      logic call_ack;
      logic return_from_interrupt;
   } tlih_core_ev_s;

   // long call request towards the core
   typedef struct packed {
      logic req;
      logic [TLIH_VEC_W-1:0] vec;
   } tlih_call_s;
endpackage

// ### hw/tlih_arbiter.sv
// level then fixed-order selection among eligible sources
module tlih_arbiter #(
   parameter int N = 19,
   parameter int IW = 5
) (
   // eligible requests and their levels
   input wire logic [N-1:0] elig,
   input wire logic [N-1:0] prio,
   // winner
   output logic valid,
   output logic hi,
   output logic [IW-1:0] idx
);
   logic [N-1:0] hi_set;

   // lowest source number wins inside a level
   always_comb
   begin
      hi_set = elig & prio;
      valid = |elig;
      hi = |hi_set;
      idx = '0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (hi ? hi_set[i] : elig[i])
         begin
            idx = IW'(i);
         end
      end
   end
endmodule

// ### bench/tlih_core_model.sv
// behavioural core pipeline facing the interrupt handler
module tlih_core_model
   import tlih_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // call request from the handler
   input wire tlih_pkg::tlih_call_s call,
   // bench controls
   input wire logic stall,
   input wire logic return_from_interrupt_go,
   input wire logic [3:0] ack_dly,
   // strobes to the handler
   output tlih_pkg::tlih_core_ev_s core_ev
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_reg;

   // a stalled core retires nothing, so a return cannot be followed by re-entry
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         core_ev <= '0;
         wait_reg <= 4'h0;
      end
      else
      begin
         core_ev.instr_done <= !stall;
         core_ev.return_from_interrupt <= return_from_interrupt_go;
         core_ev.call_ack <= 1'h0;
         // guard on the last ack: the request falls one cycle after it
         if (call.req && !core_ev.call_ack)
         begin
            if (wait_reg >= ack_dly)
            begin
               core_ev.call_ack <= 1'h1;
               wait_reg <= 4'h0;
            end
            else
               wait_reg <= wait_reg + 4'h1;
         end
         else
            wait_reg <= 4'h0;
      end
   end
endmodule

// ### bench/test_tlih_top.sv
// self-checking bench of the two-level interrupt handler
module test_tlih_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tlih_pkg::*;
   localparam logic [1:0] OK = TLIH_RESP_OKAY;
   localparam logic [1:0] ER = TLIH_RESP_SLVERR;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] awaddr = 8'h0;
   logic [7:0] araddr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [18:0] src_event = 19'h0;
   logic stall = 1'h0, return_from_interrupt_go = 1'h0;
   logic [3:0] ack_dly = 4'h0;
   tlih_core_ev_s core_ev;
   tlih_call_s call;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [15:0] vq[$];
   int bad_count = 0;
   int comparisons = 0;
   logic [31:0] seed = 32'h8262;
   logic [31:0] rnd, exp_pend;

   initial forever #20 aclk = ~aclk;

   tlih_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .src_event(src_event), .core_ev(core_ev), .call(call), .irq(irq));

   tlih_core_model core (.aclk(aclk), .aresetn(aresetn), .call(call), .stall(stall),
      .return_from_interrupt_go(return_from_interrupt_go), .ack_dly(ack_dly), .core_ev(core_ev));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [15:0] vec(input int i);
      return TLIH_VEC_BASE + TLIH_VEC_STEP * i[15:0];
   endfunction

   task automatic chk_rd(input logic [33:0] got, input logic [33:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // no cycle count assumed: only the watchdog ends a hung transfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      @(posedge aclk);
      bq.push_back(e);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end
      while (!bvalid);
      bready <= 1'h0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      @(posedge aclk);
      rq.push_back(e);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end
      while (!rvalid);
      rready <= 1'h0;
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge aclk);
   endtask

   // waits until the core has taken all but the given number of noted calls
   task automatic wait_call(input int left);
      int n;
      n = 0;
      while (vq.size() > left && n < 200)
      begin
         @(posedge aclk);
         n++;
      end
      if (vq.size() > left)
         bad_count++;
   endtask

   task automatic return_from_interrupt();
      @(posedge aclk);
      return_from_interrupt_go <= 1'h1;
      @(posedge aclk);
      return_from_interrupt_go <= 1'h0;
   endtask

   task automatic wrap_up();
      $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // a call with nothing noted is a spurious request
   always @(posedge aclk)
   begin
      if (aresetn && bvalid && bready && bq.size() != 0)
         chk_rd({bresp, 32'h0}, {bq.pop_front(), 32'h0});
      if (aresetn && rvalid && rready && rq.size() != 0)
         chk_rd({rresp, rdata}, rq.pop_front());
      if (aresetn && call.req && core_ev.call_ack)
      begin
         if (vq.size() != 0)
            chk_vec(call.vec, vq.pop_front());
         else
            chk_vec(call.vec, 16'hffff);
      end
   end

   initial
   begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      wrap_up();
   end

   initial
   begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      rd(TLIH_OFS_CTRL, {OK, 32'h0});
      rd(TLIH_OFS_PRIO, {OK, 32'h0});
      rd(TLIH_OFS_ENABLE, {OK, 32'h0});
      rd(TLIH_OFS_PEND_CLR, {OK, 32'h0});
      rd(8'h20, {ER, 32'h0});
      wr(8'h24, 32'hffff_ffff, ER);
      $display("test reset done");
      wr(TLIH_OFS_ENABLE, 32'h0000_0028, OK);
      exp_pend = 32'h8;
      // sources 10 to 18 stay disabled and must not disturb the flow
      for (int i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         rnd = (seed & 32'h0007_fc00) | 32'h8;
         exp_pend |= rnd;
         src_event <= rnd[18:0];
         @(posedge aclk);
         src_event <= 19'h0;
         @(posedge aclk);
      end
      rd(TLIH_OFS_PEND, {OK, exp_pend});
      cyc(5);
      chk_bit(call.req, 1'h0);
      vq.push_back(vec(3));
      wr(TLIH_OFS_CTRL, 32'h80, OK);
      wait_call(0);
      rd(TLIH_OFS_PEND, {OK, exp_pend & ~32'h8});
      return_from_interrupt();
      $display("test global enable done");
      ack_dly <= 4'h3;
      vq.push_back(vec(5));
      wr(TLIH_OFS_PEND, 32'h20, OK);
      wait_call(0);
      stall <= 1'h1;
      return_from_interrupt();
      cyc(6);
      chk_bit(call.req, 1'h0);
      vq.push_back(vec(5));
      stall <= 1'h0;
      wait_call(0);
      wr(TLIH_OFS_PEND_CLR, 32'hffff_ffff, OK);
      return_from_interrupt();
      $display("test re-entry done");
      ack_dly <= 4'h0;
      wr(TLIH_OFS_ENABLE, 32'h0000_02d0, OK);
      wr(TLIH_OFS_PRIO, 32'h40, OK);
      vq.push_back(vec(4));
      wr(TLIH_OFS_PEND, 32'h10, OK);
      wait_call(0);
      vq.push_back(vec(6));
      wr(TLIH_OFS_PEND, 32'h40, OK);
      wait_call(0);
      rd(TLIH_OFS_STATE, {OK, 32'h0000_0603});
      wr(TLIH_OFS_PEND_CLR, 32'h40, OK);
      wr(TLIH_OFS_PEND, 32'h2c0, OK);
      cyc(8);
      chk_bit(call.req, 1'h0);
      wr(TLIH_OFS_PEND_CLR, 32'h40, OK);
      return_from_interrupt();
      cyc(8);
      chk_bit(call.req, 1'h0);
      wr(TLIH_OFS_PEND_CLR, 32'h10, OK);
      vq.push_back(vec(7));
      vq.push_back(vec(9));
      return_from_interrupt();
      wait_call(1);
      wr(TLIH_OFS_PEND_CLR, 32'h80, OK);
      return_from_interrupt();
      wait_call(0);
      wr(TLIH_OFS_PEND_CLR, 32'h200, OK);
      return_from_interrupt();
      vq.push_back(vec(6));
      vq.push_back(vec(4));
      wr(TLIH_OFS_PEND, 32'h50, OK);
      wait_call(1);
      wr(TLIH_OFS_PEND_CLR, 32'h40, OK);
      return_from_interrupt();
      wait_call(0);
      wr(TLIH_OFS_PEND_CLR, 32'h10, OK);
      return_from_interrupt();
      $display("test priority done");
      rd(TLIH_OFS_EVT, {OK, 32'h0000_0007});
      cyc(3);
      chk_bit(irq, 1'h0);
      wr(TLIH_OFS_EVT_MASK, 32'h1, OK);
      cyc(3);
      chk_bit(irq, 1'h1);
      wr(TLIH_OFS_EVT, 32'h7, OK);
      cyc(3);
      chk_bit(irq, 1'h0);
      $display("test event interrupt done");
      wrap_up();
   end
endmodule
